/* hw/lsb_pkg.sv */
// Purpose: Shared constants for the serial break and header block.
// Assumes: All timing is counted in bit times of the 16x sampling grid.
// Notes:   Counts in ticks are derived from bit counts and OVERSAMPLE.
package lsb_pkg;
    // ========
    // Sampling grid
    localparam int OVERSAMPLE = 16;
    localparam int SAMPLE_W = 4;
    localparam int BAUD_DIV_W = 16;
    // ========
    // Character and break lengths, in bit times
    localparam int BRK_BITS_8 = 10;
    localparam int BRK_BITS_9 = 11;
    localparam int BRK_BITS_LIN = 13;
    localparam int IDLE_BITS = 10;
    localparam int GAP_BITS = 1;
    localparam int BIT_CNT_W = 4;
    // ========
    // Header supervision, in bit times and derived ticks
    localparam int BRK_DET_BITS = 11;
    localparam int HDR_TIMEOUT_BITS = 57;
    localparam int BRK_DET_TICKS = BRK_DET_BITS * OVERSAMPLE;
    localparam int HDR_TIMEOUT_TICKS = HDR_TIMEOUT_BITS * OVERSAMPLE;
    localparam int LOW_CNT_W = 8;
    localparam int HDR_CNT_W = 10;
    localparam int HDR_LEN_W = 8;
    // ========
    // Receive buffer and reset values
    localparam int DATA_W = 9;
    localparam int FIFO_DEPTH = 8;
    localparam logic [HDR_LEN_W-1:0] HDR_LEN_RESET = 8'h00;
    localparam logic MUTE_RESET = 1'b0;
endpackage

/* hw/lsb_fifo_if.sv */
// Purpose: Carrier between the receiver and its buffer.
// Assumes: Valid/ready handshake on both sides, one clock.
// Notes:   Read data on the drain side come from a register.
`timescale 1ns/1ps
interface lsb_fifo_if #(
    parameter int W = 9
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fill_src (output in_valid, output in_data, input in_ready);
    modport fill_dst (input in_valid, input in_data, output in_ready);
    modport drain_src (output out_valid, output out_data, input out_ready);
    modport drain_dst (input out_valid, input out_data, output out_ready);
endinterface

/* hw/lsb_fifo.sv */
// Purpose: Small synchronous receive buffer.
// Assumes: Single clock; push and pop in one cycle allowed.
// Notes:   Head word is held in a register, so out_data is flopped.
`timescale 1ns/1ps
module lsb_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    lsb_fifo_if.fill_dst fill,
    lsb_fifo_if.drain_src drain
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("lsb_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [W-1:0] out_data_reg;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign fill.in_ready = (count_reg != DEPTH[AW:0]);
    assign drain.out_valid = (count_reg != '0);
    assign drain.out_data = out_data_reg;
    assign push = fill.in_valid && fill.in_ready;
    assign pop = drain.out_valid && drain.out_ready;

    // Storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= fill.in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Registered head word; bypass when the buffer is empty or drains to the new word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_data_reg <= '0;
        end else if (push && (count_reg == '0 || (pop && count_reg == 1))) begin
            out_data_reg <= fill.in_data;
        end else if (pop) begin
            out_data_reg <= mem[rd_ptr_reg + 1'b1];
        end
    end
endmodule

/* hw/lsb_baud.sv */
// Purpose: Divider producing the 16x sampling enable.
// Assumes: Divisor is static while a frame is in flight.
// Notes:   A divisor of zero behaves as one, a tick every cycle.
`timescale 1ns/1ps
module lsb_baud #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] divisor,
    output logic tick
);
    initial begin
        if (W < 1) begin
            $error("lsb_baud: W must be at least 1");
        end
    end

    logic [W-1:0] cnt_reg;
    logic wrap;

    assign wrap = (divisor <= 1) || (cnt_reg >= divisor - 1'b1);
    assign tick = wrap;

    // Free-running count, restarted at each tick
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (wrap) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

/* hw/lsb_top.sv */
// Purpose: Serial line with break sending and LIN slave header supervision.
// Assumes: Software strobes are one-cycle pulses on this clock; rxd is a raw pin.
// Notes:   Transmit side sends idle and break characters only, no data.
// Notes on behaviour
// (RQ1) A slave header past 57 bits sets the header error and keeps mute.
// (RQ2) The receiver samples sixteen times per bit.
// (RQ3) A header time-out never releases mute nor sets header-detected.
// (RQ4) After a header time-out the header length reads zero.
// (RQ5) A status read then a data read clears the header error.
// (RQ6) Software may read the mute bit and set it again.
// (RQ7) One send-break pulse sends one break of 10 bits, 11 with 9-bit words.
// (RQ8) Breaks repeat back to back while send-break is held.
// (RQ9) LIN master mode is LIN enabled with 8-bit words.
// (RQ10) A LIN master break lasts 13 bit times.
// (RQ11) Software queues an idle before a break with interrupts off.
// (RQ12) A queued idle adds 10 high bit times before the break.
// (RQ13) Unmuted received bytes set receive-full and the interrupt.
// (RQ14) A master keeps a header within 49 bits and the sync-to-id gap under 4.
// (RQ15) A valid slave header sets header-detected and releases mute.
// (RQ16) A break is low its full length, then high a bit before more.
`timescale 1ns/1ps
module lsb_top #(
    parameter int DATA_W = lsb_pkg::DATA_W,
    parameter int FIFO_DEPTH = lsb_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic rxd_pin,
    output logic txd_pin,
    input wire logic [lsb_pkg::BAUD_DIV_W-1:0] baud_rate_reg,
    input wire logic lin_enable,
    input wire logic lin_slave,
    input wire logic word9,
    input wire logic tx_enable_bit,
    input wire logic send_break_bit,
    input wire logic mute_set,
    input wire logic status_read,
    input wire logic data_read,
    output logic [DATA_W-1:0] serial_data_reg,
    output logic rx_data_full_flag,
    output logic header_error_flag,
    output logic header_detected_flag,
    output logic rx_wakeup_mute,
    output logic overrun_flag,
    output logic [lsb_pkg::HDR_LEN_W-1:0] header_length_reg,
    output logic serial_irq
);
    initial begin
        if (DATA_W < 9) begin
            $error("lsb_top: DATA_W must hold a 9-bit word");
        end
    end

    // ========
    // Types
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} lsb_rx_state_t;
    typedef enum logic [1:0] {HDR_IDLE, HDR_SYNC, HDR_ID} lsb_hdr_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_BREAK, TX_GAP} lsb_tx_state_t;

    // ========
    // Declarations
    logic tick;
    logic rxd_meta_reg;
    logic rxd_sync_reg;
    logic rxd_prev_reg;
    lsb_rx_state_t rx_state_reg;
    logic [lsb_pkg::SAMPLE_W-1:0] rx_sample_reg;
    logic [lsb_pkg::BIT_CNT_W-1:0] rx_bit_reg;
    logic [DATA_W-1:0] rx_shift_reg;
    logic byte_done;
    logic [DATA_W-1:0] byte_value;
    logic [lsb_pkg::LOW_CNT_W-1:0] low_cnt_reg;
    logic break_seen;
    lsb_hdr_state_t hdr_state_reg;
    logic [lsb_pkg::HDR_CNT_W-1:0] hdr_ticks_reg;
    logic hdr_timeout;
    logic hdr_done;
    logic read_armed_reg;
    logic clear_seq;
    logic push_byte;
    lsb_tx_state_t tx_state_reg;
    logic [lsb_pkg::SAMPLE_W-1:0] tx_sub_reg;
    logic [lsb_pkg::BIT_CNT_W-1:0] tx_bit_reg;
    logic bit_tick;
    logic [lsb_pkg::BIT_CNT_W-1:0] brk_len;
    logic lin_master;
    logic tx_en_prev_reg;
    logic sbk_prev_reg;
    logic idle_req_reg;
    logic brk_req_reg;

    lsb_fifo_if #(.W(DATA_W)) rx_buf ();

    // ========
    // Sampling enable and receive buffer
    lsb_baud #(.W(lsb_pkg::BAUD_DIV_W)) u_baud (
        .clock(clock),
        .rst(rst),
        .divisor(baud_rate_reg),
        .tick(tick)
    );

    lsb_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .fill(rx_buf.fill_dst),
        .drain(rx_buf.drain_src)
    );

    // ========
    // Pin synchroniser; only the second stage is looked at
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end else begin
            rxd_meta_reg <= rxd_pin;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // ========
    // Receive framing on the 16x grid, centred mid-bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_state_reg <= RX_IDLE;
            rx_sample_reg <= '0;
            rx_bit_reg <= '0;
            rx_shift_reg <= '0;
            rxd_prev_reg <= 1'b1;
        end else if (tick) begin // RQ2
            rxd_prev_reg <= rxd_sync_reg;
            rx_sample_reg <= rx_sample_reg + 1'b1;
            case (rx_state_reg)
                RX_IDLE: begin
                    // Edge only, so a long low line does not retrigger
                    rx_sample_reg <= '0;
                    if (rxd_prev_reg && !rxd_sync_reg) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_sample_reg == 4'h7) begin
                        rx_sample_reg <= '0;
                        rx_bit_reg <= '0;
                        rx_state_reg <= rxd_sync_reg ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample_reg == 4'hf) begin
                        rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[DATA_W-1:1]};
                        rx_bit_reg <= rx_bit_reg + 1'b1;
                        if (rx_bit_reg == (word9 ? 4'h8 : 4'h7)) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_sample_reg == 4'hf) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // Good stop bit ends a character; 8-bit words are right-aligned
    assign byte_done = tick && (rx_state_reg == RX_STOP) && (rx_sample_reg == 4'hf)
        && rxd_sync_reg;
    assign byte_value = word9 ? rx_shift_reg : {1'b0, rx_shift_reg[DATA_W-1:1]};

    // ========
    // Break detection: eleven bit times of continuous low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_cnt_reg <= '0;
        end else if (tick) begin
            if (rxd_sync_reg) begin
                low_cnt_reg <= '0;
            end else if (low_cnt_reg != lsb_pkg::BRK_DET_TICKS[lsb_pkg::LOW_CNT_W-1:0]) begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end
        end
    end

    assign break_seen = tick && !rxd_sync_reg && lin_enable && lin_slave
        && (low_cnt_reg == lsb_pkg::BRK_DET_TICKS[lsb_pkg::LOW_CNT_W-1:0] - 1'b1);

    // ========
    // Slave header supervision; time counted from the break's start
    assign hdr_timeout = (hdr_state_reg != HDR_IDLE) && tick
        && (hdr_ticks_reg >= lsb_pkg::HDR_TIMEOUT_TICKS[lsb_pkg::HDR_CNT_W-1:0]); // RQ1
    assign hdr_done = (hdr_state_reg == HDR_ID) && byte_done && !hdr_timeout;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hdr_state_reg <= HDR_IDLE;
            hdr_ticks_reg <= '0;
        end else if (break_seen) begin
            hdr_state_reg <= HDR_SYNC;
            hdr_ticks_reg <= lsb_pkg::BRK_DET_TICKS[lsb_pkg::HDR_CNT_W-1:0];
        end else begin
            if (tick && hdr_state_reg != HDR_IDLE) begin
                hdr_ticks_reg <= hdr_ticks_reg + 1'b1;
            end
            case (hdr_state_reg)
                HDR_IDLE: begin
                    hdr_ticks_reg <= '0;
                end
                HDR_SYNC: begin
                    if (hdr_timeout) begin
                        hdr_state_reg <= HDR_IDLE;
                    end else if (byte_done) begin
                        hdr_state_reg <= HDR_ID;
                    end
                end
                HDR_ID: begin
                    if (hdr_timeout || hdr_done) begin
                        hdr_state_reg <= HDR_IDLE;
                    end
                end
                default: begin
                    hdr_state_reg <= HDR_IDLE;
                end
            endcase
        end
    end

    // Header length in whole bit times, zero marks a time-out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            header_length_reg <= lsb_pkg::HDR_LEN_RESET;
        end else if (hdr_timeout) begin
            header_length_reg <= lsb_pkg::HDR_LEN_RESET; // RQ4
        end else if (hdr_done) begin
            header_length_reg <= {2'b00, hdr_ticks_reg[lsb_pkg::HDR_CNT_W-1:lsb_pkg::SAMPLE_W]};
        end
    end

    // ========
    // Mute: only a good header releases it, a time-out never does
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_wakeup_mute <= lsb_pkg::MUTE_RESET;
        end else if (hdr_done) begin
            rx_wakeup_mute <= 1'b0; // RQ15
        end else if (mute_set) begin
            rx_wakeup_mute <= 1'b1; // RQ6
        end
    end

    // ========
    // Software clear: status read arms, the next data read clears
    assign clear_seq = data_read && read_armed_reg; // RQ5

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_armed_reg <= 1'b0;
        end else if (status_read) begin
            read_armed_reg <= 1'b1;
        end else if (data_read) begin
            read_armed_reg <= 1'b0;
        end
    end

    // Header flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            header_error_flag <= 1'b0;
            header_detected_flag <= 1'b0;
        end else begin
            if (hdr_timeout) begin
                header_error_flag <= 1'b1; // RQ1
            end else if (clear_seq) begin
                header_error_flag <= 1'b0; // RQ5
            end
            if (hdr_done) begin
                header_detected_flag <= 1'b1; // RQ15
            end else if (clear_seq) begin
                header_detected_flag <= 1'b0; // RQ3
            end
        end
    end

    // ========
    // Data path: header bytes and muted bytes never reach the buffer
    assign push_byte = byte_done && !rx_wakeup_mute && (hdr_state_reg == HDR_IDLE); // RQ13
    assign rx_buf.in_valid = push_byte;
    assign rx_buf.in_data = byte_value;
    assign rx_buf.out_ready = data_read;
    assign serial_data_reg = rx_buf.out_data;

    // Receive-full follows each byte; a full buffer drops it and flags overrun
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            if (push_byte && rx_buf.in_ready) begin
                rx_data_full_flag <= 1'b1; // RQ13
            end else if (clear_seq) begin
                rx_data_full_flag <= 1'b0;
            end
            if (push_byte && !rx_buf.in_ready) begin
                overrun_flag <= 1'b1;
            end else if (clear_seq) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // Serial interrupt request, level while any event flag but overrun stands
    assign serial_irq = header_error_flag | header_detected_flag | rx_data_full_flag; // RQ13

    // ========
    // Transmit bit clock: sixteen sampling ticks per bit
    assign bit_tick = tick && (tx_sub_reg == 4'hf);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_sub_reg <= '0;
        end else if (tick) begin
            tx_sub_reg <= tx_sub_reg + 1'b1;
        end
    end

    // Break length per mode
    assign lin_master = lin_enable && !word9; // RQ9
    assign brk_len = lin_master ? 4'(lsb_pkg::BRK_BITS_LIN) // RQ10
        : (word9 ? 4'(lsb_pkg::BRK_BITS_9) : 4'(lsb_pkg::BRK_BITS_8)); // RQ7

    // Requests: an enable rise queues an idle, a send-break rise queues one break
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_en_prev_reg <= 1'b0;
            sbk_prev_reg <= 1'b0;
            idle_req_reg <= 1'b0;
            brk_req_reg <= 1'b0;
        end else begin
            tx_en_prev_reg <= tx_enable_bit;
            sbk_prev_reg <= send_break_bit;
            if (tx_enable_bit && !tx_en_prev_reg) begin
                idle_req_reg <= 1'b1; // RQ12
            end else if (tx_state_reg == TX_PREAMBLE || !tx_enable_bit) begin
                idle_req_reg <= 1'b0;
            end
            // Held so a short pulse still yields its one break
            if (send_break_bit && !sbk_prev_reg) begin
                brk_req_reg <= 1'b1; // RQ7
            end else if (tx_state_reg == TX_BREAK || !tx_enable_bit) begin
                brk_req_reg <= 1'b0;
            end
        end
    end

    // Transmit sequencer: idle first, then break, then the high gap
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_state_reg <= TX_IDLE;
            tx_bit_reg <= '0;
        end else if (!tx_enable_bit) begin
            tx_state_reg <= TX_IDLE;
            tx_bit_reg <= '0;
        end else if (bit_tick) begin
            tx_bit_reg <= tx_bit_reg + 1'b1;
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_bit_reg <= '0;
                    if (idle_req_reg) begin
                        tx_state_reg <= TX_PREAMBLE;
                    end else if (brk_req_reg || send_break_bit) begin
                        tx_state_reg <= TX_BREAK; // RQ8
                    end
                end
                TX_PREAMBLE: begin
                    // Straight into a pending break, so the idle adds exactly its length
                    if (tx_bit_reg == 4'(lsb_pkg::IDLE_BITS - 1)) begin
                        tx_bit_reg <= '0;
                        tx_state_reg <= (brk_req_reg || send_break_bit) ? TX_BREAK : TX_IDLE; // RQ12
                    end
                end
                TX_BREAK: begin
                    if (tx_bit_reg == brk_len - 1'b1) begin
                        tx_bit_reg <= '0;
                        tx_state_reg <= TX_GAP; // RQ16
                    end
                end
                TX_GAP: begin
                    if (tx_bit_reg == 4'(lsb_pkg::GAP_BITS - 1)) begin
                        tx_bit_reg <= '0;
                        tx_state_reg <= (brk_req_reg || send_break_bit) ? TX_BREAK : TX_IDLE; // RQ8
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // Line is low only inside a break; registered to keep glitches off the pin
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txd_pin <= 1'b1;
        end else begin
            txd_pin <= (tx_state_reg != TX_BREAK); // RQ16
        end
    end
endmodule

/* verification/lsb_properties.sv */
// Purpose: Port-level properties of lsb_top.
// Assumes: Strobes are one-cycle pulses.
// Notes: Break lengths scale with the divisor.
`timescale 1ns/1ps
module lsb_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic txd_pin,
    input wire logic [lsb_pkg::BAUD_DIV_W-1:0] baud_rate_reg,
    input wire logic lin_enable,
    input wire logic word9,
    input wire logic mute_set,
    input wire logic data_read,
    input wire logic rx_data_full_flag,
    input wire logic header_error_flag,
    input wire logic header_detected_flag,
    input wire logic rx_wakeup_mute,
    input wire logic [lsb_pkg::HDR_LEN_W-1:0] header_length_reg,
    input wire logic serial_irq
);
    // ========
    // Line run lengths; high run saturates on long idles
    logic [15:0] lo_reg;
    logic [15:0] hi_reg;
    logic [15:0] bit_clk;
    logic [3:0] brk;
    assign bit_clk = (baud_rate_reg == 0) ? 16'h0010 : {baud_rate_reg[11:0], 4'h0};
    assign brk = (lin_enable && !word9) ? 4'hd : (word9 ? 4'hb : 4'ha);
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            lo_reg <= '0;
        else
            lo_reg <= txd_pin ? '0 : lo_reg + 1'b1;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            hi_reg <= '0;
        else
            hi_reg <= !txd_pin ? '0 : hi_reg + {15'h0000, ~&hi_reg};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_irq;
        serial_irq == (rx_data_full_flag | header_error_flag | header_detected_flag);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_len;
        $rose(header_error_flag) |-> header_length_reg == 8'h00;
    endproperty
    a_len: assert property (p_len) else $error("length not zero");
    property p_keep;
        $rose(header_error_flag) |-> rx_wakeup_mute == $past(rx_wakeup_mute)
            && !$rose(header_detected_flag);
    endproperty
    a_keep: assert property (p_keep) else $error("timeout moved mute");
    property p_det;
        $rose(header_detected_flag) |-> !rx_wakeup_mute;
    endproperty
    a_det: assert property (p_det) else $error("still muted");
    property p_mute;
        mute_set |=> rx_wakeup_mute;
    endproperty
    a_mute: assert property (p_mute) else $error("mute not set");
    property p_clr;
        $fell(header_error_flag) |-> $past(data_read);
    endproperty
    a_clr: assert property (p_clr) else $error("error cleared alone");
    property p_brk;
        $rose(txd_pin) |-> lo_reg == brk * bit_clk;
    endproperty
    a_brk: assert property (p_brk) else $error("break length");
    property p_gap;
        $fell(txd_pin) |-> hi_reg >= bit_clk;
    endproperty
    a_gap: assert property (p_gap) else $error("gap too short");
endmodule
bind lsb_top lsb_props i_props (.*);

/* verification/lsb_node.sv */
// Purpose: Far-side bus node driving the receive line.
// Assumes: One bit is BIT clocks.
// Notes: Line idles high, as with the bus pull-up.
`timescale 1ns/1ps
module lsb_node #(
    parameter int BIT = 16
) (
    input wire logic clock,
    output logic rxd
);
    initial rxd = 1'b1;
    // ========
    // Line level for n bit times
    task automatic hold(input int n, input logic v);
        rxd = v;
        repeat (n * BIT) @(negedge clock);
    endtask
    // One character, LSB first, stop bit high
    task automatic send_char(input logic [7:0] d);
        hold(1, 1'b0);
        for (int i = 0; i < 8; i++) hold(1, d[i]);
        hold(1, 1'b1);
    endtask
    // Break, delimiter, sync, gap, identifier; gap 0 keeps a legal header
    task automatic header(input int gap, input logic [7:0] id);
        hold(13, 1'b0);
        hold(1, 1'b1);
        send_char(8'h55);
        if (gap > 0) hold(gap, 1'b1);
        send_char(id);
    endtask
endmodule

/* verification/lsb_top_tb.sv */
// Purpose: Self-checking bench for lsb_top.
// Assumes: Divisor 1, so one bit is 16 clocks.
// Notes: Inputs move on the falling edge.
`timescale 1ns/1ps
module lsb_top_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic rxd_pin, txd_pin, lin_enable, lin_slave, word9, tx_enable_bit, send_break_bit;
    logic mute_set, status_read, data_read, overrun_flag, serial_irq;
    logic rx_data_full_flag, header_error_flag, header_detected_flag, rx_wakeup_mute;
    logic [8:0] serial_data_reg;
    logic [7:0] header_length_reg;
    logic [15:0] baud_rate_reg = 16'h0001;
    int errors = 0;
    int n_checks = 0;
    logic [7:0] q[$];
    always #10 clock = ~clock;
    lsb_top i_dut (.*);
    lsb_node i_node (.clock(clock), .rxd(rxd_pin));
    // ========
    // Helpers
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        @(negedge clock);
    endtask
    function automatic int brk_bits(input logic lin, input logic w9);
        return (lin && !w9) ? 13 : (w9 ? 11 : 10);
    endfunction
    task report_and_stop;
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard, well past the planned run
    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        report_and_stop();
    end
    // ========
    // Main sequence
    initial begin
        int n;
        logic [7:0] d;
        {lin_enable, lin_slave, word9, tx_enable_bit, send_break_bit} = 5'h00;
        {mute_set, status_read, data_read} = 3'h0;
        void'($urandom(32'h0000_809b));
        repeat (16) @(negedge clock);
        rst = 1'b0;
        // Overfill the buffer, then drain it in order
        for (int i = 0; i < 9; i++) begin
            d = $urandom;
            q.push_back(d);
            i_node.send_char(d);
        end
        chk(rx_data_full_flag && serial_irq && overrun_flag, "rx flags");
        pulse(status_read);
        for (int i = 0; i < 8; i++) begin
            chk(serial_data_reg === {1'b0, q[i]}, "rx data");
            pulse(data_read);
        end
        chk(!rx_data_full_flag && !overrun_flag, "flags clear");
        pulse(mute_set);
        chk(rx_wakeup_mute, "mute");
        i_node.send_char(8'h3c);
        chk(!rx_data_full_flag, "muted rx");
        // Good header, then one timing out inside the id stop bit
        {lin_enable, lin_slave} = 2'h3;
        i_node.header(0, $urandom);
        chk(header_detected_flag && !rx_wakeup_mute, "header");
        chk(header_length_reg >= 8'h21 && header_length_reg <= 8'h22, "length");
        pulse(status_read);
        pulse(data_read);
        pulse(mute_set);
        i_node.header(24, $urandom);
        chk(header_error_flag && !header_detected_flag, "timeout");
        chk(header_length_reg === 8'h00 && rx_wakeup_mute, "timeout state");
        pulse(data_read);
        chk(header_error_flag, "refused clear");
        pulse(status_read);
        pulse(data_read);
        chk(!header_error_flag, "error clear");
        // Idle then one break, every mode
        lin_slave = 1'b0;
        for (int m = 0; m < 4; m++) begin
            {lin_enable, word9} = m[1:0];
            tx_enable_bit = 1'b0;
            @(negedge clock);
            tx_enable_bit = 1'b1;
            pulse(send_break_bit);
            for (n = 2; n < 400 && txd_pin; n++) @(negedge clock);
            chk(n >= 160 && n <= 180, "idle");
            for (n = 0; n < 400 && !txd_pin; n++) @(negedge clock);
            chk(n == 16 * brk_bits(m[1], m[0]), "break");
            repeat (48) @(negedge clock);
            chk(txd_pin, "single break");
        end
        // Held send-break repeats with one gap bit
        {lin_enable, word9} = 2'h2;
        send_break_bit = 1'b1;
        for (n = 0; n < 400 && txd_pin; n++) @(negedge clock);
        for (int k = 0; k < 2; k++) begin
            for (n = 0; n < 400 && !txd_pin; n++) @(negedge clock);
            for (; n < 800 && txd_pin; n++) @(negedge clock);
            chk(n == 224, "repeat");
        end
        send_break_bit = 1'b0;
        repeat (300) @(negedge clock);
        report_and_stop();
    end
endmodule
